// File: core/irq_ctrl.sv
// two-level interrupt controller with avalon-mm register slave
// assumes the core samples irq_req at instruction boundaries and pulses
// vec_take when it jumps to irq_vector and ret_pulse on return_from_service
//
// What this block does
// - one priority bit per source, two levels
// - high request preempts running low routine
// - running high routine blocks all requests
// - high level chosen over low
// - equal level: lowest vector address wins
// - core finishes instruction, pushes pc, jumps vector
// - return ends in-service state of that level
// - same-level arrivals stay pending until return
// - global enable bit 7 masks all sources
// - main enable bits 6..0 seven sources
// - main priority bits 6..0, bit 7 reserved
// - second enable bits 7..0 eight sources
// - second priority bits 7..0 same order
// - third enable: serial2 bit1, serial1 bit0
// - third priority: serial2 bit1, serial1 bit0
// - request needs flag, own enable, global enable
// - vectors 0003h upward step eight to 0083h
// - timer0/timer1 flags cleared on acceptance
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
module irq_ctrl (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst,
  // avalon-mm slave
  input  wire logic [7:0]                         avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  input  wire logic [3:0]                         avs_byteenable,
  output logic      [31:0]                        avs_readdata,
  output logic                                    avs_waitrequest,
  output logic [1:0]                              avs_response,
  // peripheral flags
  input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0]   src_flag,
  // cpu core side
  input  wire logic                               vec_take,
  input  wire logic                               ret_pulse,
  output logic                                    irq_req,
  output logic [irq_ctrl_pkg::VEC_W-1:0]          irq_vector,
  output logic                                    timer0_flag_clr,
  output logic                                    timer1_flag_clr,
  output logic [1:0]                              in_service
);

  // registers
  logic [7:0]                        en_main_r;
  logic [7:0]                        en_second_r;
  logic [7:0]                        en_third_r;
  logic [7:0]                        pri_main_r;
  logic [7:0]                        pri_second_r;
  logic [7:0]                        pri_third_r;
  logic                              srv_high_r;
  logic                              srv_low_r;
  irq_ctrl_pkg::bus_state_t          bus_r;

  // per-source enable and level vectors
  logic [irq_ctrl_pkg::NUM_SRC-1:0]  src_en;
  logic [irq_ctrl_pkg::NUM_SRC-1:0]  src_level;
  logic [irq_ctrl_pkg::NUM_SRC-1:0]  pend;
  logic [irq_ctrl_pkg::NUM_SRC-1:0]  pend_hi;
  logic [irq_ctrl_pkg::NUM_SRC-1:0]  pend_lo;
  logic                              sel_valid;
  logic                              sel_high;
  logic [4:0]                        sel_idx;
  logic                              allow_hi;
  logic                              allow_lo;
  logic                              req_nxt;
  logic [irq_ctrl_pkg::VEC_W-1:0]    vec_nxt;
  logic                              sel_high_r;
  logic [4:0]                        sel_idx_r;

  // source bit ordering: index equals polling order
  assign src_en    = {en_third_r[1:0], en_second_r, en_main_r[6:0]};
  assign src_level = {pri_third_r[1:0], pri_second_r, pri_main_r[6:0]};

  // request qualification
  assign pend    = src_flag & src_en
                 & {irq_ctrl_pkg::NUM_SRC{en_main_r[irq_ctrl_pkg::GLOBAL_EN_BIT]}};
  assign pend_hi = pend & src_level;
  assign pend_lo = pend & ~src_level;

  // nesting gates
  assign allow_hi = ~srv_high_r;
  assign allow_lo = ~srv_high_r & ~srv_low_r;

  // fixed polling, high level first
  always_comb begin
    sel_valid = 1'b0;
    sel_high  = 1'b0;
    sel_idx   = 5'h00;
    for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend_lo[i] && allow_lo) begin
        sel_valid = 1'b1;
        sel_idx   = 5'(i);
      end
    end
    for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend_hi[i] && allow_hi) begin
        sel_valid = 1'b1;
        sel_high  = 1'b1;
        sel_idx   = 5'(i);
      end
    end
  end

  assign req_nxt = sel_valid;
  assign vec_nxt = irq_ctrl_pkg::VEC_BASE
                 + irq_ctrl_pkg::VEC_W'({11'h000, sel_idx} * irq_ctrl_pkg::VEC_STEP);

  // request and vector outputs, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req    <= 1'b0;
      irq_vector <= 16'h0000;
      sel_high_r <= 1'b0;
      sel_idx_r  <= 5'h00;
    end else if (vec_take && irq_req) begin
      irq_req    <= 1'b0;
      irq_vector <= irq_vector;
      sel_high_r <= sel_high_r;
      sel_idx_r  <= sel_idx_r;
    end else begin
      irq_req    <= req_nxt;
      irq_vector <= vec_nxt;
      sel_high_r <= sel_high;
      sel_idx_r  <= sel_idx;
    end
  end

  // in-service tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srv_high_r <= 1'b0;
      srv_low_r  <= 1'b0;
    end else begin
      if (vec_take && irq_req && sel_high_r) begin
        srv_high_r <= 1'b1;
      end else if (ret_pulse && srv_high_r) begin
        srv_high_r <= 1'b0;
      end
      if (vec_take && irq_req && !sel_high_r) begin
        srv_low_r <= 1'b1;
      end else if (ret_pulse && !srv_high_r && srv_low_r) begin
        srv_low_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_service <= 2'b00;
    end else begin
      in_service <= {srv_high_r, srv_low_r};
    end
  end

  // hardware flag clear for timer0 and timer1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer0_flag_clr <= 1'b0;
      timer1_flag_clr <= 1'b0;
    end else begin
      timer0_flag_clr <= vec_take && irq_req
                         && (sel_idx_r == 5'(irq_ctrl_pkg::SRC_TIMER0));
      timer1_flag_clr <= vec_take && irq_req
                         && (sel_idx_r == 5'(irq_ctrl_pkg::SRC_TIMER1));
    end
  end

  // register writes, low byte lane only
  logic wr_ok;
  assign wr_ok = avs_write && avs_byteenable[0] && (bus_r == irq_ctrl_pkg::BUS_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_main_r    <= irq_ctrl_pkg::REG_RESET;
      en_second_r  <= irq_ctrl_pkg::REG_RESET;
      en_third_r   <= irq_ctrl_pkg::REG_RESET;
      pri_main_r   <= irq_ctrl_pkg::REG_RESET;
      pri_second_r <= irq_ctrl_pkg::REG_RESET;
      pri_third_r  <= irq_ctrl_pkg::REG_RESET;
    end else if (wr_ok) begin
      unique case (avs_address)
        irq_ctrl_pkg::OFS_EN_MAIN:    en_main_r    <= avs_writedata[7:0];
        irq_ctrl_pkg::OFS_EN_SECOND:  en_second_r  <= avs_writedata[7:0];
        irq_ctrl_pkg::OFS_EN_THIRD:   en_third_r   <= avs_writedata[7:0] & irq_ctrl_pkg::THIRD_MASK;
        irq_ctrl_pkg::OFS_PRI_MAIN:   pri_main_r   <= avs_writedata[7:0] & irq_ctrl_pkg::MAIN_MASK;
        irq_ctrl_pkg::OFS_PRI_SECOND: pri_second_r <= avs_writedata[7:0];
        irq_ctrl_pkg::OFS_PRI_THIRD:  pri_third_r  <= avs_writedata[7:0] & irq_ctrl_pkg::THIRD_MASK;
        default: ;
      endcase
    end
  end

  // bus reply: one wait cycle, then acknowledge
  logic [7:0] rd_byte;
  logic       hit;
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    unique case (avs_address)
      irq_ctrl_pkg::OFS_EN_MAIN:    rd_byte = en_main_r;
      irq_ctrl_pkg::OFS_EN_SECOND:  rd_byte = en_second_r;
      irq_ctrl_pkg::OFS_EN_THIRD:   rd_byte = en_third_r;
      irq_ctrl_pkg::OFS_PRI_MAIN:   rd_byte = pri_main_r;
      irq_ctrl_pkg::OFS_PRI_SECOND: rd_byte = pri_second_r;
      irq_ctrl_pkg::OFS_PRI_THIRD:  rd_byte = pri_third_r;
      irq_ctrl_pkg::OFS_STATUS:     rd_byte = {5'h00, irq_req, srv_high_r, srv_low_r};
      default:                      hit     = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_r           <= irq_ctrl_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'b00;
    end else begin
      unique case (bus_r)
        irq_ctrl_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_r           <= irq_ctrl_pkg::BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h000000, rd_byte};
            avs_response    <= hit ? 2'b00 : 2'b10;
          end else begin
            avs_waitrequest <= 1'b1;
          end
        end
        irq_ctrl_pkg::BUS_ACK: begin
          bus_r           <= irq_ctrl_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

endmodule

// File: core/irq_ctrl_pkg.sv
// constants for the two-level interrupt controller
// assumes an avalon-mm slave with byte offsets equal to the register offsets
package irq_ctrl_pkg;
  localparam int                 NUM_SRC        = 17;
  localparam int                 VEC_W          = 16;
  // register offsets
  localparam logic [7:0]         OFS_EN_MAIN    = 8'ha8;
  localparam logic [7:0]         OFS_EN_SECOND  = 8'ha9;
  localparam logic [7:0]         OFS_EN_THIRD   = 8'haa;
  localparam logic [7:0]         OFS_PRI_MAIN   = 8'hb8;
  localparam logic [7:0]         OFS_PRI_SECOND = 8'hb9;
  localparam logic [7:0]         OFS_PRI_THIRD  = 8'hba;
  localparam logic [7:0]         OFS_STATUS     = 8'hc0;
  // field positions and masks
  localparam int                 GLOBAL_EN_BIT  = 7;
  localparam logic [7:0]         MAIN_MASK      = 8'h7f;
  localparam logic [7:0]         THIRD_MASK     = 8'h03;
  localparam logic [7:0]         REG_RESET      = 8'h00;
  // vector layout
  localparam logic [VEC_W-1:0]   VEC_BASE       = 16'h0003;
  localparam logic [VEC_W-1:0]   VEC_STEP       = 16'h0008;
  // source indices with hardware-cleared flags
  localparam int                 SRC_TIMER0     = 1;
  localparam int                 SRC_TIMER1     = 3;
  // bus reply states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage

// File: tb/irq_ctrl_checker.sv
// port assertions for irq_ctrl
// bound to every irq_ctrl instance
`timescale 1ns/1ns
module irq_ctrl_checker (
  // clock and reset
  input wire logic                             clk,
  input wire logic                             rst,
  // bus
  input wire logic                             avs_read,
  input wire logic                             avs_write,
  input wire logic                             avs_waitrequest,
  // core side
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] src_flag,
  input wire logic                             vec_take,
  input wire logic                             irq_req,
  input wire logic [irq_ctrl_pkg::VEC_W-1:0]   irq_vector,
  input wire logic                             timer0_flag_clr,
  input wire logic                             timer1_flag_clr,
  input wire logic [1:0]                       in_service
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    vec_take && irq_req;
  endsequence
  sequence s_quiet;
    (src_flag == '0) [*2];
  endsequence
  property p_drop; s_take |=> !irq_req; endproperty
  a_drop: assert property (p_drop)
    else $error("request stayed after take");
  property p_clr0; s_take ##0 irq_vector == 16'h000b |=> timer0_flag_clr; endproperty
  a_clr0: assert property (p_clr0)
    else $error("timer0 flag not cleared");
  property p_clr1; timer1_flag_clr |-> $past(vec_take && irq_req && irq_vector == 16'h001b);
  endproperty
  a_clr1: assert property (p_clr1)
    else $error("stray timer1 clear");
  property p_ins; s_take |-> ##2 in_service != 2'b00; endproperty
  a_ins: assert property (p_ins)
    else $error("no level in service after take");
  property p_idle; s_quiet |=> !irq_req; endproperty
  a_idle: assert property (p_idle)
    else $error("request without flag");
  property p_vec; irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0083; endproperty
  a_vec: assert property (p_vec)
    else $error("bad vector");
  property p_hi; $rose(in_service[1]) |-> !irq_req [*3]; endproperty
  a_hi: assert property (p_hi)
    else $error("request during high service");
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer late");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one)
    else $error("answer longer than one cycle");
endmodule
bind irq_ctrl irq_ctrl_checker u_chk (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .src_flag, .vec_take, .irq_req, .irq_vector, .timer0_flag_clr, .timer1_flag_clr, .in_service);

// File: tb/core_model.sv
// core sequencer model: takes vectors, stacks them, returns
// stall delays a take; each routine lasts eight cycles
`timescale 1ns/1ns
module core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // controller side
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        stall,
  output logic             vec_take,
  output logic             ret_pulse
);
  logic [15:0] stack_q[$];
  logic [15:0] taken_q[$];
  int          svc_cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_take  <= 1'b0;
      ret_pulse <= 1'b0;
      svc_cnt   <= 0;
    end else begin
      vec_take  <= 1'b0;
      ret_pulse <= 1'b0;
      if (vec_take && irq_req) begin
        stack_q.push_back(irq_vector);
        taken_q.push_back(irq_vector);
        svc_cnt <= 8;
      end else if (irq_req && !stall && !ret_pulse) begin
        vec_take <= 1'b1;
      end else if (svc_cnt > 1) begin
        svc_cnt <= svc_cnt - 1;
      end else if (svc_cnt == 1) begin
        ret_pulse <= 1'b1;
        void'(stack_q.pop_back());
        svc_cnt <= (stack_q.size() != 0) ? 8 : 0;
      end
    end
  end
endmodule

// File: tb/two_level_interrupt_controller_tb.sv
// random and directed bench for irq_ctrl
// assumes irq_ctrl_pkg, core_model and the bound checker
`timescale 1ns/1ns
module two_level_interrupt_controller_tb;
  logic        clk, rst, rd, wr, wt, stall, tk, rp, req, c0, c1;
  logic [7:0]  adr, q, d;
  logic [31:0] wd, rdat;
  logic [1:0]  rsp, rs, ins;
  logic [16:0] flags, post, tmask, hi, f;
  logic [15:0] vec;
  logic [7:0]  ofs[6] = '{8'ha8, 8'ha9, 8'haa, 8'hb8, 8'hb9, 8'hba};
  logic [7:0]  msk[6] = '{8'hff, 8'hff, 8'h03, 8'h7f, 8'hff, 8'h03};
  logic [15:0] exp4[4] = '{16'h0083, 16'h0003, 16'h0083, 16'h0023};
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  irq_ctrl dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt),
    .avs_response(rsp), .src_flag(flags), .vec_take(tk), .ret_pulse(rp), .irq_req(req),
    .irq_vector(vec), .timer0_flag_clr(c0), .timer1_flag_clr(c1), .in_service(ins));
  core_model m (.clk(clk), .rst(rst), .irq_req(req), .irq_vector(vec), .stall(stall),
    .vec_take(tk), .ret_pulse(rp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // flags clear when taken, as software or hardware would
  assign tmask = (tk && req) ? 17'h1 << ((vec - 16'h3) >> 3) : '0;
  always @(posedge clk) begin
    flags <= (flags & ~tmask) | post;
    stall <= ($urandom % 3) == 0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [7:0] v);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, v};
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    q = rdat[7:0];
    rs = rsp;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic raise(logic [16:0] v);
    post <= v;
    @(posedge clk);
    post <= '0;
  endtask
  function automatic logic [15:0] first_vec(logic [16:0] fl, logic [16:0] h);
    logic [16:0] s;
    s = ((fl & h) != 0) ? (fl & h) : fl;
    for (int i = 16; i >= 0; i--) if (s[i]) first_vec = 16'h3 + 16'(i) * 16'h8;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {rd, wr, stall, adr, wd, flags, post} = '0;
    void'($urandom(32'h6d020b8d));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (ofs[i]) begin
      bus(0, ofs[i], 0);
      chk("reset", q, 0);
      d = $urandom;
      bus(1, ofs[i], d);
      bus(0, ofs[i], 0);
      chk("readback", q, d & msk[i]);
    end
    bus(0, 8'hc0, 0);
    chk("status", q, 0);
    bus(0, 8'h10, 0);
    chk("unmapped", rs, 2'b10);
    $display("test registers done");
    bus(1, 8'ha8, 8'hff);
    bus(1, 8'ha9, 8'hff);
    bus(1, 8'haa, 8'h03);
    for (int n = 0; n < 12; n++) begin
      hi = $urandom;
      f = (n == 0) ? '1 : 17'($urandom) | 17'h1;
      bus(1, 8'hb8, {1'b0, hi[6:0]});
      bus(1, 8'hb9, hi[14:7]);
      bus(1, 8'hba, {6'h0, hi[16:15]});
      m.taken_q.delete();
      raise(f);
      while (m.taken_q.size() == 0) @(posedge clk);
      chk("first", m.taken_q[0], first_vec(f, hi));
      while (flags != 0 || m.stack_q.size() != 0) @(posedge clk);
    end
    $display("test arbitration done");
    bus(1, 8'ha8, 8'h7f);
    m.taken_q.delete();
    raise(17'h8);
    repeat (20) @(posedge clk);
    chk("masked", m.taken_q.size(), 0);
    bus(1, 8'ha8, 8'hff);
    while (m.taken_q.size() == 0) @(posedge clk);
    chk("unmasked", m.taken_q[0], 16'h001b);
    while (m.stack_q.size() != 0) @(posedge clk);
    $display("test global enable done");
    bus(1, 8'hb8, 8'h00);
    bus(1, 8'hb9, 8'h00);
    bus(1, 8'hba, 8'h02);
    m.taken_q.delete();
    raise(17'h10001);
    while (m.taken_q.size() < 2) @(posedge clk);
    raise(17'h10010);
    while (flags != 0 || m.stack_q.size() != 0) @(posedge clk);
    chk("count", m.taken_q.size(), 4);
    foreach (exp4[i]) chk("order", m.taken_q[i], exp4[i]);
    $display("test nesting done");
    tally_and_finish();
  end
endmodule
